/* core/acc_regs.svh */
// constants for the converter control block: address, bit positions, reset, timing
// assumes an 8-bit special function register bus with bit addressing
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

`define ACC_CTRL_ADDR      8'hE8
`define ACC_CTRL_RESET     8'h00
`define ACC_BIT_ON         7
`define ACC_BIT_TRACK      6
`define ACC_BIT_DONE       5
`define ACC_BIT_ACTIVE     4
`define ACC_BIT_WIN        3
`define ACC_MODE_HI        2
`define ACC_MODE_LO        0
`define ACC_BIT_ADDR_BASE  8'hE8
`define ACC_BIT_ADDR_TOP   8'hEF
`define ACC_MODE_SOFTWARE  3'h0
`define ACC_MODE_EVENT1    3'h1
`define ACC_MODE_EVENT2    3'h2
`define ACC_MODE_EVENT3    3'h3
`define ACC_MODE_EVENT4    3'h4
`define ACC_TRACK_EXTRA    2'h3

`endif

/* core/acc_pkg.sv */
// types shared by the converter control block
// assumes nothing beyond the constants header
package acc_pkg;
  typedef logic [7:0] acc_byte_type;
  typedef logic [9:0] acc_result_type;
  typedef logic [3:0] acc_event_type;
  typedef enum logic [1:0] {ACC_IDLE, ACC_DELAY, ACC_CONVERT} acc_state_type;
endpackage

/* core/acc_track_delay.sv */
// counts the extra tracking periods of delayed track mode
// assumes sar_tick is a one-cycle enable pulse at the SAR clock rate
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_track_delay
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       begin_delay,
  input  wire logic       abort,
  input  wire logic       sar_tick,
  // result
  output logic            expired
);
  logic       running_q;
  logic [1:0] count_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      running_q <= 1'b0;
      count_q   <= 2'h0;
      expired   <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (abort)
      begin
        running_q <= 1'b0;
        count_q   <= 2'h0;
      end
      else if (begin_delay)
      begin
        running_q <= 1'b1;
        count_q   <= 2'h0;
      end
      else if (running_q && sar_tick)
      begin
        // partial sar periods count: the first tick after the start closes period one, the third ends the delay
        if (count_q == (`ACC_TRACK_EXTRA - 2'h1))
        begin
          running_q <= 1'b0;
          count_q   <= 2'h0;
          expired   <= 1'b1;
        end
        else
          count_q <= count_q + 2'h1;
      end
    end
  end
endmodule

/* core/acc_window.sv */
// window compare of a converter result against the two limits
// assumes limits come from registers held elsewhere, on the same clock
`timescale 1ns/1ps
module acc_window
(
  // compare inputs
  input  wire acc_pkg::acc_result_type result,
  input  wire acc_pkg::acc_result_type gt_limit,
  input  wire acc_pkg::acc_result_type lt_limit,
  // verdict
  output logic                         match
);
  import acc_pkg::*;

  always_comb
  begin
    // limits ordered one way mean inside the window, the other way outside
    if (lt_limit > gt_limit)
      match = (result > gt_limit) && (result < lt_limit);
    else
      match = (result > gt_limit) || (result < lt_limit);
  end
endmodule

/* core/acc_ctrl.sv */
// control and status register of the 10-bit converter with its start sequencer
// assumes an 8-bit sfr bus with byte and bit writes, and a converter core on SYS_CLK
//
// Notes on behaviour
// - With the on bit at 0 the converter is held in shutdown and never converts.
// - With the on bit at 1 the converter is powered and start events are accepted.
// - Normal tracking follows the input except during conversion and starts at once.
// - Delayed tracking adds three SAR clock periods of tracking before converting.
// - In delayed tracking the input is tracked whenever no conversion runs.
// - The done flag becomes 1 when a conversion completes.
// - The done flag stays 0 until a completion after clearing; software clears it.
// - The active bit reads 1 while the sequencer is in the extra tracking delay or converting, and 0 otherwise.
// - Writing 1 to the active bit starts a conversion only in mode 000; 0 does nothing.
// - The window flag reads 0 until a window match occurs, then 1.
// - The register lives at sfr address E8, is bit addressable and resets to zero.
// - Bits 2 to 0 select which event starts a conversion.
// - Every result is compared with the limits and a match sets the window flag.
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_ctrl
(
  // clock and reset
  input  wire logic                    SYS_CLK,
  input  wire logic                    SYS_RST,
  // sfr byte access
  input  wire acc_pkg::acc_byte_type   SFR_ADDR,
  input  wire logic                    SFR_WR,
  input  wire acc_pkg::acc_byte_type   SFR_WDATA,
  input  wire logic                    SFR_RD,
  output acc_pkg::acc_byte_type        SFR_RDATA,
  // sfr bit access
  input  wire acc_pkg::acc_byte_type   SFR_BIT_ADDR,
  input  wire logic                    SFR_BIT_WR,
  input  wire logic                    SFR_BIT_WDATA,
  // start events and sar rate
  input  wire acc_pkg::acc_event_type  START_EVENT,
  input  wire logic                    SAR_TICK,
  // window limits
  input  wire acc_pkg::acc_result_type WIN_GT_LIMIT,
  input  wire acc_pkg::acc_result_type WIN_LT_LIMIT,
  // converter core
  output logic                         CONV_ENABLE,
  output logic                         CONV_TRACK,
  output logic                         CONV_START,
  input  wire logic                    CONV_DONE,
  input  wire acc_pkg::acc_result_type CONV_RESULT,
  // result register write
  output logic                         RESULT_WE,
  output acc_pkg::acc_result_type      RESULT_DATA
);
  import acc_pkg::*;

  acc_state_type  state_q;
  acc_state_type  state_d;
  logic           on_q;
  logic           track_sel_q;
  logic           done_q;
  logic           win_q;
  logic [2:0]     mode_q;
  acc_byte_type   ctrl_byte;
  acc_byte_type   wr_mask;
  acc_byte_type   wr_value;
  logic [2:0]     mode_next;
  logic           sw_start;
  logic           hw_start;
  logic           start_ok;
  logic           delay_begin;
  logic           delay_expired;
  logic           delay_abort;
  logic           conv_finish;
  logic           win_match;
  logic [2:0]     bit_sel;
  logic           byte_hit;
  logic           bit_hit;
  logic           rd_hit;

  // bit position of a bit write, meaningful only inside the register's range
  assign bit_sel = SFR_BIT_ADDR[2:0];

  // a byte write to the register outranks a bit write in the same cycle
  assign byte_hit = SFR_WR && (SFR_ADDR == `ACC_CTRL_ADDR);
  assign bit_hit  = SFR_BIT_WR && (SFR_BIT_ADDR >= `ACC_BIT_ADDR_BASE)
                    && (SFR_BIT_ADDR <= `ACC_BIT_ADDR_TOP);

  // reads answer only for this register address
  assign rd_hit = SFR_RD && (SFR_ADDR == `ACC_CTRL_ADDR);

  // merge byte and bit writes into one mask and value
  always_comb
  begin
    wr_mask  = 8'h00;
    wr_value = 8'h00;
    if (byte_hit)
    begin
      wr_mask  = 8'hFF;
      wr_value = SFR_WDATA;
    end
    else if (bit_hit)
    begin
      wr_mask[bit_sel]  = 1'b1;
      wr_value[bit_sel] = SFR_BIT_WDATA;
    end
  end

  // the mode as it will stand after this write, so one byte can select and start
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_mode_next
      assign mode_next[g] = wr_mask[g] ? wr_value[g] : mode_q[g];
    end
  endgenerate

  // software start: active bit written with 1, mode software, writing 0 is ignored
  assign sw_start = wr_mask[`ACC_BIT_ACTIVE] && wr_value[`ACC_BIT_ACTIVE]
                    && (mode_next == `ACC_MODE_SOFTWARE);

  // hardware start sources; reserved codes select nothing
  always_comb
  begin
    unique case (mode_q)
      `ACC_MODE_EVENT1: hw_start = START_EVENT[0];
      `ACC_MODE_EVENT2: hw_start = START_EVENT[1];
      `ACC_MODE_EVENT3: hw_start = START_EVENT[2];
      `ACC_MODE_EVENT4: hw_start = START_EVENT[3];
      default:          hw_start = 1'b0;
    endcase
  end

  // starts only count when powered and idle
  assign start_ok = on_q && (state_q == ACC_IDLE) && (sw_start || hw_start);

  // switching off drops whatever is in flight
  assign delay_abort = !on_q;
  assign delay_begin = start_ok && track_sel_q;
  assign conv_finish = (state_q == ACC_CONVERT) && CONV_DONE && on_q;

  acc_track_delay u_delay
  (
    .clk         (SYS_CLK),
    .rst         (SYS_RST),
    .begin_delay (delay_begin),
    .abort       (delay_abort),
    .sar_tick    (SAR_TICK),
    .expired     (delay_expired)
  );

  acc_window u_window
  (
    .result   (CONV_RESULT),
    .gt_limit (WIN_GT_LIMIT),
    .lt_limit (WIN_LT_LIMIT),
    .match    (win_match)
  );

  // start sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ACC_IDLE:
      begin
        if (start_ok && !track_sel_q)
          state_d = ACC_CONVERT;
        else if (start_ok)
          state_d = ACC_DELAY;
      end
      ACC_DELAY:
      begin
        if (!on_q)
          state_d = ACC_IDLE;
        else if (delay_expired)
          state_d = ACC_CONVERT;
      end
      ACC_CONVERT:
      begin
        if (!on_q || conv_finish)
          state_d = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      state_q <= ACC_IDLE;
    else
      state_q <= state_d;
  end

  // converter on bit
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      on_q <= 1'b0;
    else if (wr_mask[`ACC_BIT_ON])
      on_q <= wr_value[`ACC_BIT_ON];
  end

  // track select bit
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      track_sel_q <= 1'b0;
    else if (wr_mask[`ACC_BIT_TRACK])
      track_sel_q <= wr_value[`ACC_BIT_TRACK];
  end

  // start source select; reserved codes are kept and simply select no source
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      mode_q <= `ACC_MODE_SOFTWARE;
    else
      mode_q <= mode_next;
  end

  // done flag: completion wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      done_q <= 1'b0;
    else if (conv_finish)
      done_q <= 1'b1;
    else if (wr_mask[`ACC_BIT_DONE])
      done_q <= wr_value[`ACC_BIT_DONE];
  end

  // window flag: a match wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      win_q <= 1'b0;
    else if (conv_finish && win_match)
      win_q <= 1'b1;
    else if (wr_mask[`ACC_BIT_WIN])
      win_q <= wr_value[`ACC_BIT_WIN];
  end

  // live register image; active bit comes straight from the sequencer
  always_comb
  begin
    ctrl_byte                                = `ACC_CTRL_RESET;
    ctrl_byte[`ACC_BIT_ON]                   = on_q;
    ctrl_byte[`ACC_BIT_TRACK]                = track_sel_q;
    ctrl_byte[`ACC_BIT_DONE]                 = done_q;
    ctrl_byte[`ACC_BIT_ACTIVE]               = (state_q != ACC_IDLE);
    ctrl_byte[`ACC_BIT_WIN]                  = win_q;
    ctrl_byte[`ACC_MODE_HI:`ACC_MODE_LO]     = mode_q;
  end

  // read data one cycle after the strobe; other addresses answer zero
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      SFR_RDATA <= 8'h00;
    else if (rd_hit)
      SFR_RDATA <= ctrl_byte;
    else
      SFR_RDATA <= 8'h00;
  end

  // converter power follows the on bit one cycle late
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      CONV_ENABLE <= 1'b0;
    else
      CONV_ENABLE <= on_q;
  end

  // tracking follows the next state so it drops together with the start pulse
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      CONV_TRACK <= 1'b0;
    else
      CONV_TRACK <= on_q && (state_d != ACC_CONVERT);
  end

  // one-cycle start pulse to the core, at once or after the extra tracking
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      CONV_START <= 1'b0;
    else
      CONV_START <= (state_q != ACC_CONVERT) && (state_d == ACC_CONVERT);
  end

  // result write strobe on the same edge that clears busy and sets done
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      RESULT_WE <= 1'b0;
    else
      RESULT_WE <= conv_finish;
  end

  // result held until the next completion
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      RESULT_DATA <= 10'h000;
    else if (conv_finish)
      RESULT_DATA <= CONV_RESULT;
  end
endmodule

/* tb/acc_ctrl_properties.sv */
// timing relations of the converter control block seen at its ports
// assumes a bind onto acc_ctrl with every input tied to the port of the same name
`timescale 1ns/1ps
module acc_ctrl_properties
(
  // clock and reset
  input wire logic                    SYS_CLK,
  input wire logic                    SYS_RST,
  // sfr access
  input wire acc_pkg::acc_byte_type   SFR_ADDR,
  input wire logic                    SFR_WR,
  input wire acc_pkg::acc_byte_type   SFR_WDATA,
  input wire logic                    SFR_RD,
  input wire acc_pkg::acc_byte_type   SFR_RDATA,
  input wire acc_pkg::acc_byte_type   SFR_BIT_ADDR,
  input wire logic                    SFR_BIT_WR,
  // converter core and result
  input wire logic                    CONV_ENABLE,
  input wire logic                    CONV_TRACK,
  input wire logic                    CONV_START,
  input wire logic                    CONV_DONE,
  input wire acc_pkg::acc_result_type CONV_RESULT,
  input wire logic                    RESULT_WE,
  input wire acc_pkg::acc_result_type RESULT_DATA
);
  import acc_pkg::*;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  start_needs_on_a: assert property (CONV_START |-> CONV_ENABLE)
    else $error("start while converter off");
  enable_follows_a: assert property (SFR_WR && SFR_ADDR == 8'hE8 |->
    ##2 CONV_ENABLE == $past(SFR_WDATA[7], 2)) else $error("enable not following on bit");
  start_pulse_a: assert property (CONV_START |=> !CONV_START)
    else $error("start longer than one cycle");
  start_hold_a: assert property (CONV_START |-> !CONV_TRACK)
    else $error("tracking during start");
  result_cause_a: assert property (RESULT_WE |->
    $past(CONV_DONE) && RESULT_DATA == $past(CONV_RESULT)) else $error("result write bad");
  result_pulse_a: assert property (RESULT_WE |=> !RESULT_WE)
    else $error("result write longer than one cycle");
  track_after_a: assert property (RESULT_WE && CONV_ENABLE |-> CONV_TRACK)
    else $error("no tracking after completion");
  idle_read_a: assert property (!(SFR_RD && SFR_ADDR == 8'hE8) |=> SFR_RDATA == 8'h00)
    else $error("read data without read");
  flags_done_a: assert property (RESULT_WE ##1 (SFR_RD && SFR_ADDR == 8'hE8) |=>
    SFR_RDATA[5] && !SFR_RDATA[4]) else $error("flags wrong after completion");
  cover property (CONV_START);
  cover property (RESULT_WE && CONV_TRACK);
  cover property (SFR_BIT_WR && SFR_BIT_ADDR == 8'hEC);
endmodule

/* tb/acc_core_model.sv */
// behavioural converter core: answers a start after a fixed latency
// assumes enable and start come from the control block on the same clock
`timescale 1ns/1ps
module acc_core_model
#(
  parameter int LAT = 8
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control from the block
  input  wire logic       enable,
  input  wire logic       start,
  // analog value and answer
  input  wire logic [9:0] value,
  output logic            done,
  output logic [9:0]      result
);
  int cnt;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      done <= 1'b0;
      result <= 10'h000;
    end
    else
    begin
      done <= (cnt == 1) && enable;
      // result only valid with done, so scramble it otherwise
      result <= (cnt == 1) ? value : ~result;
      if (!enable)
        cnt <= 0;
      else if (start)
        cnt <= LAT;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule

/* tb/tb_acc_ctrl.sv */
// self-checking bench for the converter control register and start sequencer
// assumes the core model answers each start after its fixed latency
`timescale 1ns/1ps
module tb_acc_ctrl;
  import acc_pkg::*;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  acc_byte_type   addr = 8'h00;
  acc_byte_type   wdata = 8'h00;
  acc_byte_type   baddr = 8'h00;
  acc_byte_type   rdat;
  logic           wr_s = 1'b0;
  logic           rd_s = 1'b0;
  logic           bwr = 1'b0;
  logic           bwd = 1'b0;
  logic           tick = 1'b0;
  logic [1:0]     tc = 2'h0;
  acc_event_type  ev = 4'h0;
  acc_result_type gt = 10'h3FF;
  acc_result_type lt = 10'h000;
  acc_result_type val = 10'h2A5;
  acc_result_type cres;
  acc_result_type res;
  logic           en;
  logic           trk;
  logic           st;
  logic           cdone;
  logic           we;
  int             ticks = 0;
  int             bad_count = 0;
  int             n_tests = 0;
  always #2.5 clk = ~clk;
  always @(negedge clk)
  begin
    tc <= tc + 2'h1;
    tick <= (tc == 2'h3);
  end
  always @(posedge clk)
    if (tick)
      ticks++;
  acc_ctrl i_acc_ctrl (.SYS_CLK(clk), .SYS_RST(rst), .SFR_ADDR(addr), .SFR_WR(wr_s),
    .SFR_WDATA(wdata), .SFR_RD(rd_s), .SFR_RDATA(rdat), .SFR_BIT_ADDR(baddr),
    .SFR_BIT_WR(bwr), .SFR_BIT_WDATA(bwd), .START_EVENT(ev), .SAR_TICK(tick),
    .WIN_GT_LIMIT(gt), .WIN_LT_LIMIT(lt), .CONV_ENABLE(en), .CONV_TRACK(trk),
    .CONV_START(st), .CONV_DONE(cdone), .CONV_RESULT(cres), .RESULT_WE(we),
    .RESULT_DATA(res));
  acc_core_model i_acc_core_model (.clk(clk), .rst(rst), .enable(en), .start(st),
    .value(val), .done(cdone), .result(cres));
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input acc_byte_type a, input acc_byte_type d);
    // idle edge first, so back-to-back calls never drop and raise a strobe at once
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic rd(input acc_byte_type a, input acc_byte_type e);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk("register", {2'h0, e}, {2'h0, rdat});
  endtask
  task automatic bw(input logic [2:0] b, input logic v);
    @(negedge clk);
    baddr = {5'h1D, b};
    bwd = v;
    bwr = 1'b1;
    @(negedge clk);
    bwr = 1'b0;
  endtask
  task automatic pulse(input logic [1:0] i);
    ev = 4'h1 << i;
    @(negedge clk);
    ev = 4'h0;
  endtask
  // waits a bounded span for start (s=0) or result write (s=1)
  task automatic wt(input logic s, input int lim, input logic e);
    int i;
    for (i = 0; i < lim && !(s ? we : st); i++)
      @(negedge clk);
    chk(s ? "done" : "start", {9'h0, e}, {9'h0, s ? we : st});
  endtask
  initial
  begin
    #100000;
    bad_count++;
    summarize();
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rd(8'hE8, 8'h00);
    wr(8'hE9, 8'h80);
    rd(8'hE0, 8'h00);
    wr(8'hE8, 8'h10);
    wt(1'b0, 6, 1'b0);
    rd(8'hE8, 8'h00);
    wr(8'hE8, 8'h80);
    bw(3'h4, 1'b0);
    rd(8'hE8, 8'h80);
    chk("enable", 10'h1, {9'h0, en});
    wr(8'hE8, 8'h90);
    wt(1'b0, 3, 1'b1);
    rd(8'hE8, 8'h90);
    wt(1'b1, 20, 1'b1);
    chk("result", 10'h2A5, res);
    rd(8'hE8, 8'hA0);
    bw(3'h5, 1'b0);
    rd(8'hE8, 8'h80);
    gt = 10'h100;
    lt = 10'h3FF;
    val = 10'h155;
    bw(3'h4, 1'b1);
    wt(1'b0, 3, 1'b1);
    wt(1'b1, 20, 1'b1);
    rd(8'hE8, 8'hA8);
    for (acc_byte_type m = 8'h01; m <= 8'h04; m++)
    begin
      wr(8'hE8, 8'h80 | m);
      bw(3'h4, 1'b1);
      pulse(m[1:0]);
      wt(1'b0, 4, 1'b0);
      pulse(2'(m - 8'h01));
      wt(1'b0, 3, 1'b1);
      wt(1'b1, 20, 1'b1);
    end
    wr(8'hE8, 8'h90);
    wt(1'b0, 3, 1'b1);
    wr(8'hE8, 8'h00);
    wt(1'b1, 20, 1'b0);
    rd(8'hE8, 8'h00);
    chk("enable", 10'h0, {9'h0, en});
    gt = 10'h100;
    lt = 10'h080;
    val = 10'h2A5;
    wr(8'hE8, 8'hC0);
    wr(8'hE8, 8'hD0);
    ticks = 0;
    chk("track", 10'h1, {9'h0, trk});
    wt(1'b0, 30, 1'b1);
    chk("ticks", 10'h3, 10'(ticks));
    wt(1'b1, 20, 1'b1);
    chk("result", 10'h2A5, res);
    chk("track", 10'h1, {9'h0, trk});
    rd(8'hE8, 8'hE8);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("enable", 10'h0, {9'h0, en});
    rd(8'hE8, 8'h00);
    summarize();
  end
endmodule
bind acc_ctrl acc_ctrl_properties i_acc_ctrl_properties (.SYS_CLK(SYS_CLK),
  .SYS_RST(SYS_RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
  .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .SFR_BIT_ADDR(SFR_BIT_ADDR),
  .SFR_BIT_WR(SFR_BIT_WR), .CONV_ENABLE(CONV_ENABLE), .CONV_TRACK(CONV_TRACK),
  .CONV_START(CONV_START), .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT),
  .RESULT_WE(RESULT_WE), .RESULT_DATA(RESULT_DATA));
